// file: logic/sock_defs.svh
`ifndef SOCK_DEFS_SVH
`define SOCK_DEFS_SVH

// Register byte offsets on the APB bus
`define OFS_EVENT 8'h00
`define OFS_MASK 8'h04
`define OFS_PRESENT 8'h08
`define OFS_FORCE 8'h0C

// Event and mask bit positions
`define EVT_W 4
`define EVT_PWR 3
`define EVT_CD_B 2
`define EVT_CD_A 1
`define EVT_STS 0

// Force register: re-interrogation request bit
`define FRC_RETEST 14

// Reserved span of the present-state register
`define RSVD_HI 27
`define RSVD_LO 14

// Reset values
`define CAP_RESET 4'h3
`define CD_RESET 2'h3
`define EVT_RESET 4'h0
`define MASK_RESET 4'h0
`define VOLT_RESET 4'h0

`endif

// file: logic/sock_pkg.sv
// Types shared by the socket status block
package sock_pkg;

    // Layout of the present-state word, bit 31 first
    typedef struct packed {
        logic [3:0] socket_cap;      // Y.Y, X.X, 3.3, 5 volt supplies
        logic [13:0] rsvd;           // Always zero
        logic [3:0] card_volt;       // Y.Y, X.X, 3.3, 5 volt acceptance
        logic invalid_supply_request;
        logic removal_data_loss;
        logic unrecognised_card;
        logic card_irq_pin_level;
        logic wide_card_found;
        logic narrow_card_found;
        logic socket_power_state;
        logic detect_pin_b_level;
        logic detect_pin_a_level;
        logic status_change_pin_level;
    } present_s;

    // Result handed over by the card interrogation sequencer
    typedef struct packed {
        logic [3:0] card_volt;       // Supplies the card accepts
        logic unrecognised;          // Card could not be identified
        logic wide;                  // 32-bit card
        logic narrow;                // 16-bit card
    } interrog_s;

endpackage

// file: logic/pin_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser for pin levels from outside the clock domain
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff; // First stage, read only by the second
    logic [WIDTH-1:0] sync_ff; // Second stage, safe to use

    // Refuse a width the logic cannot serve
    if (WIDTH < 1) begin : g_chk
        $error("pin_sync width must be at least one");
    end

    // Both stages clocked together
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= RESET_VAL;
            sync_ff <= RESET_VAL;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule // pin_sync

// file: logic/change_detect.sv
`timescale 1ns/100ps
// Per-bit rising and falling edge detector on same-clock levels
module change_detect #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Watched levels and their edges
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] prev_ff; // Level seen one cycle ago

    // Refuse a width the logic cannot serve
    if (WIDTH < 1) begin : g_chk
        $error("change_detect width must be at least one");
    end

    // Remember the previous level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_ff <= RESET_VAL;
        end else begin
            prev_ff <= level;
        end
    end

    // One edge detector per bit
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        assign rise[i] = level[i] & ~prev_ff[i];
        assign fall[i] = ~level[i] & prev_ff[i];
    end
endmodule // change_detect

// file: logic/socket_present_state_status.sv
`timescale 1ns/100ps
`include "sock_defs.svh"
// How it works
// - force-event writes update present-state bits
// - card voltage and type load only on insertion or force write
// - detect bits frozen during card identification
// - Y.Y and X.X supply bits reset 0
// - 3.3 and 5 volt supply bits reset 1
// - bits 27 to 14 read zero
// - bits 13..10 give card supply acceptance
// - bit 9 flags invalid supply request
// - bit 8 flags possible removal data loss
// - bit 7 flags unrecognised card until valid
// - bit 6 mirrors card interrupt pin
// - bits 5,4 give wide/narrow card type
// - bit 3 reports socket power state
// - bits 2,1 mirror both detect pins
// - bit 0 mirrors status-change pin
// - power, detect, status changes set events
// - wide cards rising edge, narrow both edges
// - force bits 31..28, 13..7 and 5,4 write matching present bits
module socket_present_state_status #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Card socket pins, asynchronous
    input wire logic DETECT_A_PIN,
    input wire logic DETECT_B_PIN,
    input wire logic STATUS_CHANGE_PIN,
    input wire logic CARD_IRQ_PIN,
    // Card interrogation sequencer
    input wire logic INTERROG_BUSY,
    input wire logic INTERROG_DONE,
    input wire sock_pkg::interrog_s INTERROG_RESULT,
    output logic REINTERROGATE,
    // Power switch side
    input wire logic SOCKET_POWERED,
    input wire logic INVALID_SUPPLY_REQ,
    input wire logic REMOVAL_LOSS,
    // Status change interrupt
    output logic IRQ
);
    import sock_pkg::*;

    // Refuse an address bus too narrow for the offsets
    if (ADDR_W < 8) begin : g_chk
        $error("ADDR_W must be at least 8");
    end

    // Address match against a register offset
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] o);
        return a == ADDR_W'(o);
    endfunction

    // Bus state
    logic pready_ff; // Answer strobe, one cycle
    logic pslverr_ff; // Unmapped address answer
    logic [31:0] prdata_ff; // Captured read data
    logic access; // Access phase present
    logic take; // Access completes this edge
    logic mapped; // Address decodes to a register
    logic force_wr; // Completed write to the force register
    logic mask_wr; // Completed write to the mask register
    logic event_rd; // Completed read of the event register
    logic [31:0] rd_mux; // Read data selected by address
    present_s fwr; // Write data seen in present layout

    // Present-state storage
    logic [3:0] cap_ff; // Socket supply capability
    logic [3:0] volt_ff; // Card supply acceptance
    logic bad_ff; // Invalid supply request seen
    logic loss_ff; // Removal may have lost data
    logic nocard_ff; // Unrecognised card inserted
    logic wide_ff; // 32-bit card found
    logic narrow_ff; // 16-bit card found
    logic power_ff; // Socket powered
    logic [1:0] cd_ff; // Detect levels, B then A
    present_s present; // Assembled register word

    // Synchronised pins and edges
    logic [3:0] pins; // Irq, detect B, detect A, status change
    logic [3:0] rise; // Rising edges of watched levels
    logic [3:0] fall; // Falling edges of watched levels

    // Event, mask and interrupt
    logic [3:0] event_ff; // Sticky event bits
    logic [3:0] mask_ff; // Interrupt enables
    logic [3:0] set_evt; // Hardware and forced sets
    logic [3:0] clr_evt; // Bits cleared by a read
    logic [3:0] nxt_event; // Next event value
    logic irq_ff; // Registered interrupt level
    logic retest_ff; // Re-interrogation request pulse

    // Pin synchroniser, reset to no card and idle pins
    pin_sync #(
        .WIDTH(4),
        .RESET_VAL({1'b0, `CD_RESET, 1'b0})
    ) u_pins (
        .clk(REF_CLK),
        .nrst(NRST),
        .async_in({CARD_IRQ_PIN, DETECT_B_PIN, DETECT_A_PIN, STATUS_CHANGE_PIN}),
        .sync_out(pins)
    );

    // Edge detector on power, detect and status-change levels
    change_detect #(
        .WIDTH(4),
        .RESET_VAL({1'b0, `CD_RESET, 1'b0})
    ) u_edges (
        .clk(REF_CLK),
        .nrst(NRST),
        .level({power_ff, cd_ff, pins[0]}),
        .rise(rise),
        .fall(fall)
    );

    // Bus decode
    assign access = PSEL & PENABLE;
    assign take = access & pready_ff;
    assign mapped = reg_hit(PADDR, `OFS_EVENT) | reg_hit(PADDR, `OFS_MASK)
                  | reg_hit(PADDR, `OFS_PRESENT) | reg_hit(PADDR, `OFS_FORCE);
    assign force_wr = take & PWRITE & reg_hit(PADDR, `OFS_FORCE);
    assign mask_wr = take & PWRITE & reg_hit(PADDR, `OFS_MASK);
    assign event_rd = take & ~PWRITE & reg_hit(PADDR, `OFS_EVENT);
    assign fwr = present_s'(PWDATA);

    // Present-state word
    always_comb begin
        present = '0;
        present.socket_cap = cap_ff;
        present.card_volt = volt_ff;
        present.invalid_supply_request = bad_ff;
        present.removal_data_loss = loss_ff;
        present.unrecognised_card = nocard_ff;
        present.card_irq_pin_level = pins[3];
        present.wide_card_found = wide_ff;
        present.narrow_card_found = narrow_ff;
        present.socket_power_state = power_ff;
        present.detect_pin_b_level = cd_ff[1];
        present.detect_pin_a_level = cd_ff[0];
        present.status_change_pin_level = pins[0];
    end

    // Read data mux, unmapped and write-only read zero
    always_comb begin
        rd_mux = 32'h00000000;
        if (reg_hit(PADDR, `OFS_EVENT)) begin
            rd_mux = {28'h0000000, event_ff};
        end else if (reg_hit(PADDR, `OFS_MASK)) begin
            rd_mux = {28'h0000000, mask_ff};
        end else if (reg_hit(PADDR, `OFS_PRESENT)) begin
            rd_mux = present;
        end
    end

    // Answer one cycle into the access phase
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= access & ~pready_ff;
            if (access & ~pready_ff) begin
                pslverr_ff <= ~mapped;
                prdata_ff <= PWRITE ? 32'h00000000 : rd_mux;
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    // Socket supply capability, changed only by force writes
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            cap_ff <= `CAP_RESET;
        end else if (force_wr) begin
            cap_ff <= fwr.socket_cap;
        end
    end

    // Card voltage and type, latched per insertion
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            volt_ff <= `VOLT_RESET;
            wide_ff <= 1'b0;
            narrow_ff <= 1'b0;
        end else if (force_wr) begin
            volt_ff <= fwr.card_volt;
            wide_ff <= fwr.wide_card_found;
            narrow_ff <= fwr.narrow_card_found;
        end else if (INTERROG_DONE) begin
            volt_ff <= INTERROG_RESULT.card_volt;
            wide_ff <= INTERROG_RESULT.wide;
            narrow_ff <= INTERROG_RESULT.narrow;
        end
    end

    // Unrecognised card flag, held until the next identification
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            nocard_ff <= 1'b0;
        end else if (force_wr) begin
            nocard_ff <= fwr.unrecognised_card;
        end else if (INTERROG_DONE) begin
            nocard_ff <= INTERROG_RESULT.unrecognised;
        end
    end

    // Error flags; a hardware set wins over a forced clear
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            bad_ff <= 1'b0;
            loss_ff <= 1'b0;
        end else begin
            if (INVALID_SUPPLY_REQ) begin
                bad_ff <= 1'b1;
            end else if (force_wr) begin
                bad_ff <= fwr.invalid_supply_request;
            end
            if (REMOVAL_LOSS) begin
                loss_ff <= 1'b1;
            end else if (force_wr) begin
                loss_ff <= fwr.removal_data_loss;
            end
        end
    end

    // Power state and detect levels
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            power_ff <= 1'b0;
            cd_ff <= `CD_RESET;
        end else begin
            power_ff <= SOCKET_POWERED;
            if (!INTERROG_BUSY) begin
                cd_ff <= pins[2:1];
            end
        end
    end

    // Event sets: both edges, but status change falling edge only while narrow_ff is set
    always_comb begin
        set_evt = rise | fall;
        set_evt[`EVT_STS] = rise[`EVT_STS] | (narrow_ff & fall[`EVT_STS]);
        if (force_wr) begin
            set_evt = set_evt | PWDATA[3:0];
        end
        clr_evt = event_rd ? prdata_ff[3:0] : 4'h0;
        nxt_event = (event_ff & ~clr_evt) | set_evt;
    end

    // Sticky events, cleared only for bits actually returned
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            event_ff <= `EVT_RESET;
        end else begin
            event_ff <= nxt_event;
        end
    end

    // Mask register
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            mask_ff <= `MASK_RESET;
        end else if (mask_wr) begin
            mask_ff <= PWDATA[3:0];
        end
    end

    // Interrupt level and re-interrogation pulse
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            irq_ff <= 1'b0;
            retest_ff <= 1'b0;
        end else begin
            irq_ff <= |(event_ff & mask_ff);
            retest_ff <= force_wr & PWDATA[`FRC_RETEST];
        end
    end

    // Outputs straight from flops
    assign PRDATA = prdata_ff;
    assign PREADY = pready_ff;
    assign PSLVERR = pslverr_ff;
    assign IRQ = irq_ff;
    assign REINTERROGATE = retest_ff;

    // Checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    AST_RSVD_ZERO: assert property (
        access & ~pready_ff & ~PWRITE & reg_hit(PADDR, `OFS_PRESENT)
        |=> PRDATA[`RSVD_HI:`RSVD_LO] == 14'h0000)
        else $error("reserved present bits read nonzero");
    AST_CAP_HOLD: assert property (
        !force_wr |=> $stable(cap_ff))
        else $error("supply capability changed without a force write");
    AST_CAP_FORCE: assert property (
        force_wr |=> cap_ff == $past(PWDATA[31:28]))
        else $error("supply capability not taken from force write");
    AST_TYPE_HOLD: assert property (
        !force_wr && !INTERROG_DONE |=> $stable(volt_ff) && $stable({wide_ff, narrow_ff}))
        else $error("card voltage or type changed outside insertion");
    AST_TYPE_LOAD: assert property (
        INTERROG_DONE && !force_wr
        |=> {volt_ff, wide_ff, narrow_ff} == $past({INTERROG_RESULT.card_volt,
            INTERROG_RESULT.wide, INTERROG_RESULT.narrow}))
        else $error("interrogation result not latched");
    AST_FORCE_BITS: assert property (
        force_wr |=> {volt_ff, nocard_ff, wide_ff, narrow_ff}
            == $past({PWDATA[13:10], PWDATA[7], PWDATA[5:4]}))
        else $error("force write did not reach present bits");
    AST_CD_FROZEN: assert property (
        INTERROG_BUSY |=> $stable(cd_ff))
        else $error("detect bits moved during identification");
    AST_CD_MIRROR: assert property (
        !INTERROG_BUSY && $stable({DETECT_B_PIN, DETECT_A_PIN})[*3]
        |=> cd_ff == $past({DETECT_B_PIN, DETECT_A_PIN}))
        else $error("detect bits do not follow pins");
    AST_IRQ_PIN: assert property (
        $stable(CARD_IRQ_PIN)[*3] |-> present.card_irq_pin_level == CARD_IRQ_PIN)
        else $error("card interrupt bit does not follow pin");
    AST_STS_PIN: assert property (
        $stable(STATUS_CHANGE_PIN)[*3] |-> present.status_change_pin_level == STATUS_CHANGE_PIN)
        else $error("status change bit does not follow pin");
    AST_BAD_SET: assert property (
        INVALID_SUPPLY_REQ |=> bad_ff)
        else $error("invalid supply request not flagged");
    AST_LOSS_SET: assert property (
        REMOVAL_LOSS |=> loss_ff)
        else $error("data loss not flagged");
    AST_NOCARD: assert property (
        !force_wr && !INTERROG_DONE |=> $stable(nocard_ff))
        else $error("unrecognised flag changed without identification");
    AST_POWER: assert property (
        1'b1 |=> power_ff == $past(SOCKET_POWERED))
        else $error("power state not tracking request");
    AST_PWR_EVENT: assert property (
        $changed(power_ff) |=> event_ff[`EVT_PWR])
        else $error("power change did not set event");
    AST_STS_WIDE: assert property (
        $fell(pins[0]) && !narrow_ff && !event_ff[`EVT_STS] && !force_wr
        |=> !event_ff[`EVT_STS])
        else $error("falling status edge raised event for wide card");
    AST_IRQ_OUT: assert property (
        |(event_ff & mask_ff) |=> IRQ)
        else $error("unmasked event without interrupt");
    AST_ONE_WAIT: assert property (
        access && !pready_ff |=> PREADY ##1 !PREADY)
        else $error("answer not one cycle after access");

    COV_FORCE: cover property (force_wr ##1 REINTERROGATE);
    COV_INSERT: cover property (INTERROG_BUSY ##[1:20] INTERROG_DONE);
    COV_READ_CLR: cover property (event_rd && prdata_ff[3:0] != 4'h0);
    COV_IRQ: cover property ($rose(IRQ));
endmodule // socket_present_state_status

// file: verif/card_model.sv
`timescale 1ns/100ps
// Behavioural card at the far side of the socket pins
module card_model #(
    parameter int LAG = 3 // One less than the cycles between the two detect contacts closing
) (
    // Clock for contact timing
    input wire logic clk,
    // Commanded card state
    input wire logic inserted,
    input wire logic sts,
    input wire logic irq,
    // Socket pins
    output logic det_a,
    output logic det_b,
    output logic sts_pin,
    output logic irq_pin
);
    logic [7:0] cnt_ff = 8'h00; // Cycles the contacts have disagreed
    logic b_ff = 1'h1; // Second contact, closes late

    // Second contact follows the first after LAG+1 cycles
    always @(posedge clk) begin
        if (b_ff == det_a) begin
            cnt_ff <= 8'h00;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
            if (cnt_ff >= LAG) begin
                b_ff <= det_a;
            end
        end
    end
    assign det_a = ~inserted; // Pull-up reads high with no card
    assign det_b = b_ff;
    assign sts_pin = inserted ? sts : 1'h0; // Pull-down when empty
    assign irq_pin = inserted ? irq : 1'h1; // Pull-up when empty
endmodule // card_model

// file: verif/socket_present_state_status_test.sv
`timescale 1ns/100ps
`include "sock_defs.svh"
// Self-checking bench for the present-state status block
module socket_present_state_status_test;
    import sock_pkg::*;
    // Expected answer of one bus transfer
    typedef struct packed {
        logic err;
        logic [31:0] d;
        logic [31:0] m;
    } note_s;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, irq, reint;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, d;
    logic det_a, det_b, sts_pin, irq_pin, busy, done, powered, bad_req, loss;
    logic inserted, sts_cmd, irq_cmd;
    interrog_s res;
    // Expected register fields
    logic [3:0] e_cap, e_volt;
    logic e_bad, e_loss, e_unrec, e_wide, e_narrow, e_pwr;
    logic [1:0] e_det;
    note_s q[$]; // Notes of pending answers
    note_s cur;
    int n_fail, tests_run, n_reint;
    int seed = 27;

    socket_present_state_status #(.ADDR_W(12)) socket_present_state_status_inst (
        .REF_CLK(ref_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .DETECT_A_PIN(det_a),
        .DETECT_B_PIN(det_b), .STATUS_CHANGE_PIN(sts_pin), .CARD_IRQ_PIN(irq_pin),
        .INTERROG_BUSY(busy), .INTERROG_DONE(done), .INTERROG_RESULT(res),
        .REINTERROGATE(reint), .SOCKET_POWERED(powered),
        .INVALID_SUPPLY_REQ(bad_req), .REMOVAL_LOSS(loss), .IRQ(irq));
    card_model #(.LAG(3)) card_model_inst (.clk(ref_clk), .inserted(inserted),
        .sts(sts_cmd), .irq(irq_cmd), .det_a(det_a), .det_b(det_b),
        .sts_pin(sts_pin), .irq_pin(irq_pin));

    // Clock generator
    initial begin
        ref_clk = 1'h0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Expected present-state word
    function logic [31:0] pres();
        return {e_cap, 14'h0000, e_volt, e_bad, e_loss, e_unrec, inserted ? irq_cmd : 1'h1,
            e_wide, e_narrow, e_pwr, e_det, inserted & sts_cmd};
    endfunction

    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // One APB transfer; the expected answer is noted first
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input note_s n);
        int t;
        q.push_back(n);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= {4'h0, a};
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'h1;
        t = 0;
        // Hold the request until pready is seen high at a rising edge, bounded
        do begin
            @(posedge ref_clk);
            t++;
        end while (pready !== 1'h1 && t < 50);
        if (pready !== 1'h1) begin
            fail("no answer");
        end
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0, {1'h0, e, ALL});
    endtask

    task wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'h1, a, wd, {1'h0, 32'h0, ALL});
    endtask

    task fail(input string s);
        n_fail++;
        $display("CHECK FAILED %0t %s", $time, s);
    endtask

    // Compare a level output
    task chk(input logic v, input logic e);
        tests_run++;
        if (v !== e) fail("level mismatch");
    endtask

    // Compare one bus answer with its note
    task chk_rd(input note_s n);
        tests_run++;
        if (pslverr !== n.err || ((prdata ^ n.d) & n.m) !== 32'h0) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h expected %h", $time, prdata, n.d);
        end
    endtask

    // Answer watcher, samples where outputs have settled
    always @(negedge ref_clk) begin
        if (pready === 1'h1) begin
            if (q.size() == 0) begin
                fail("answer without request");
            end else begin
                cur = q.pop_front();
                chk_rd(cur);
            end
        end
    end

    // Count re-interrogation pulses
    always @(negedge ref_clk) begin
        if (reint === 1'h1) n_reint++;
    end

    // Hand over an interrogation result
    task load(input interrog_s v);
        res <= v;
        done <= 1'h1;
        cyc(1);
        done <= 1'h0;
        e_volt = v.card_volt;
        e_unrec = v.unrecognised;
        e_wide = v.wide;
        e_narrow = v.narrow;
        cyc(3);
    endtask

    task finish_test();
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        cyc(20000);
        fail("watchdog");
        finish_test();
    end

    // Main sequence
    initial begin
        {psel, penable, pwrite, busy, done, powered, bad_req, loss} = 8'h00;
        {paddr, pwdata, res} = '0;
        {inserted, sts_cmd, irq_cmd, nrst} = 4'h2;
        {e_cap, e_volt, e_det} = 10'h0C3;
        {e_bad, e_loss, e_unrec, e_wide, e_narrow, e_pwr} = 6'h00;
        cyc(6);
        nrst <= 1'h1;
        cyc(10);
        rd(`OFS_PRESENT, pres());
        rd(`OFS_EVENT, 32'h0);
        apb(1'h0, 8'h10, 32'h0, {1'h1, 32'h0, ALL});
        wr(`OFS_PRESENT, ALL);
        rd(`OFS_PRESENT, pres());
        $display("test reset done");
        // Insertion while identification runs
        busy <= 1'h1;
        inserted <= 1'h1;
        cyc(16);
        rd(`OFS_PRESENT, pres());
        busy <= 1'h0;
        e_det = 2'h0;
        cyc(16);
        rd(`OFS_PRESENT, pres());
        rd(`OFS_EVENT, 32'h6);
        rd(`OFS_EVENT, 32'h0);
        $display("test detect done");
        // Interrogation results, then a stale result
        for (int i = 0; i < 3; i++) begin
            r = $random(seed);
            load('{card_volt: r[3:0], unrecognised: (i == 0), wide: i[0], narrow: ~i[0]});
            rd(`OFS_PRESENT, pres());
        end
        res <= 7'h7F;
        cyc(4);
        rd(`OFS_PRESENT, pres());
        $display("test interrogation done");
        // Status-change edges for narrow then wide cards
        for (int k = 0; k < 2; k++) begin
            load('{card_volt: e_volt, unrecognised: 1'h0, wide: k[0], narrow: ~k[0]});
            sts_cmd <= 1'h1;
            irq_cmd <= k[0];
            cyc(12);
            rd(`OFS_PRESENT, pres());
            rd(`OFS_EVENT, 32'h1);
            sts_cmd <= 1'h0;
            cyc(12);
            rd(`OFS_EVENT, {31'h0, ~k[0]});
        end
        $display("test status change done");
        // Power state, event and interrupt
        wr(`OFS_MASK, 32'h8);
        rd(`OFS_MASK, 32'h8);
        powered <= 1'h1;
        e_pwr = 1'h1;
        cyc(8);
        chk(irq, 1'h1);
        rd(`OFS_PRESENT, pres());
        rd(`OFS_EVENT, 32'h8);
        cyc(4);
        chk(irq, 1'h0);
        wr(`OFS_MASK, 32'h0);
        powered <= 1'h0;
        e_pwr = 1'h0;
        cyc(8);
        chk(irq, 1'h0);
        rd(`OFS_EVENT, 32'h8);
        $display("test power done");
        // Supply request and data loss flags
        bad_req <= 1'h1;
        cyc(1);
        bad_req <= 1'h0;
        loss <= 1'h1;
        cyc(1);
        loss <= 1'h0;
        {e_bad, e_loss} = 2'h3;
        cyc(4);
        rd(`OFS_PRESENT, pres());
        $display("test flags done");
        // Force write with re-interrogation request
        r = $random(seed);
        d = (r & 32'hF0003FB0) | 32'h00004005;
        n_reint = 0;
        wr(`OFS_FORCE, d);
        cyc(4);
        e_cap = d[31:28];
        {e_volt, e_bad, e_loss, e_unrec} = d[13:7];
        {e_wide, e_narrow} = d[5:4];
        rd(`OFS_PRESENT, pres());
        rd(`OFS_EVENT, 32'h5);
        rd(`OFS_FORCE, 32'h0);
        chk(n_reint == 1, 1'h1);
        $display("test force done");
        cyc(4);
        if (q.size() != 0) fail("answers missing");
        finish_test();
    end
endmodule // socket_present_state_status_test
